// File: hdl/bbr_addr_xlate.sv
`timescale 1ns/100ps
// address translator: byte enables to coprocessor address bits
module bbr_addr_xlate
  import bbr_pkg::*;
(
  input  wire logic [3:0] byte_en,             // processor byte enables
  input  wire logic       second_half,         // 1 during second halfword
  output logic            byte_select_bit,     // low byte address bit
  output logic            halfword_select_bit, // halfword select
  output logic            high_byte_enable     // high byte enable
);

  // lanes of the half in use; a single word always starts at the low half
  logic [1:0] lanes;

  always_comb begin
    lanes               = second_half ? byte_en[3:2] : byte_en[1:0];
    halfword_select_bit = second_half;
    byte_select_bit     = ~lanes[0] & lanes[1];
    high_byte_enable    = lanes[1];
  end

endmodule

// File: hdl/bbr_bridge.sv
`timescale 1ns/100ps
module bbr_bridge
  import bbr_pkg::*;
(
  input  wire logic         mclk,             // 10 MHz system clock
  input  wire logic         rst,              // async reset, active high
  input  wire bbr_cpu_req_t cpu_req,          // processor bus request, same clock
  input  wire logic         slave_access_ack, // coprocessor ack, from a pin
  input  wire logic [15:0]  cop_rdata,        // coprocessor read data
  output bbr_cop_cmd_t      cop_cmd,          // command to coprocessor
  output bbr_xcvr_t         xcvr,             // transceiver controls
  output logic [31:0]       cpu_rdata,        // assembled read word
  output logic              half_word_done,   // per-half ready pulse
  output logic              cpu_ready,        // ready to processor
  output logic              transfer_active   // transfer_active
);

  // all state of the bridge in one record; the sequencer fills a copy and one
  // register stage takes it, so no output can be driven from two places
  typedef struct packed {
    bbr_state_t  state;
    logic [3:0]  count;
    logic        second_half;
    logic        active;
    logic        write;
    logic        mem_io;
    logic [3:0]  byte_en;
    logic [31:0] wword;
    logic [31:0] rword;
    logic [15:0] wdata_out;   // write half already chosen for the data pins
    logic        done;
    logic        ready;
    logic        latch;
    logic [1:0]  ack_sync;
  } bbr_regs_t;

  bbr_regs_t r;
  bbr_regs_t next_r;
  logic      ack;
  logic      sel_bs;
  logic      sel_hw;
  logic      sel_hb;

  // one 16-bit half of a processor word; upper picks bits 31:16
  function automatic logic [15:0] half_of(input logic [31:0] word, input logic upper);
    half_of = upper ? word[BBR_HIGH_LSB +: 16] : word[BBR_LOW_LSB +: 16];
  endfunction

  // true when any byte lane of the chosen half is enabled
  function automatic logic lanes_on(input logic [3:0] be, input logic upper);
    lanes_on = upper ? (|be[3:2]) : (|be[1:0]);
  endfunction

  // second synchroniser stage only; first stage feeds nothing else
  // the pin is never read directly: a level caught mid-change would split the
  // state decode and the enables across two different values
  assign ack = r.ack_sync[1];

  // translator sees only registered inputs, so its outputs stay steady per half
  bbr_addr_xlate bbr_addr_xlate_i (
    .byte_en             (r.byte_en),
    .second_half         (r.second_half),
    .byte_select_bit     (sel_bs),
    .halfword_select_bit (sel_hw),
    .high_byte_enable    (sel_hb)
  );

  // sequencer: count, command, wait ack, wait ack release, repeat
  // one access walks idle, count, command, ack, then count again for the upper half.
  // the ack pin is seen two cycles late through the synchroniser, so every ack
  // decision below works on the delayed copy; this costs cycles per half but
  // keeps an unsettled pin level out of the state decode.
  // a half ends on the falling ack, not the rising one: the coprocessor may still
  // be moving data while ack stands, and read data is sampled up to the last cycle.
  // limitation: a coprocessor that never drops ack holds the processor forever,
  // since the bridge has no timeout of its own.
  always_comb begin
    next_r          = r;
    next_r.ack_sync = {r.ack_sync[0], slave_access_ack};
    next_r.done     = 1'b0;
    next_r.ready    = 1'b0;
    next_r.latch    = 1'b0;
    case (r.state)
      BBR_IDLE: begin
        // start of cycle only from strobe, data enable and device select together
        // the access is copied here; later changes on the processor bus are not seen
        if (cpu_req.addr_strobe && cpu_req.data_enable && cpu_req.device_select) begin
          next_r.active      = 1'b1;
          next_r.write       = cpu_req.write;
          next_r.mem_io      = cpu_req.mem_io;
          next_r.byte_en     = cpu_req.byte_en;
          next_r.wword       = cpu_req.wdata;
          next_r.second_half = 1'b0;
          next_r.count       = BBR_CNT_RESET;
          next_r.state       = BBR_COUNT;
        end
      end
      BBR_COUNT: begin
        // counts every cycle in this state; select and transfer_active are not checked
        next_r.count = r.count + 4'h1;
        if (r.count == BBR_CMD_DELAY) begin
          next_r.state = BBR_CMD;
        end
      end
      BBR_CMD: begin
        // command stands until the coprocessor has taken the access
        if (ack) begin
          next_r.state = BBR_ACK;
        end
      end
      BBR_ACK: begin
        // half ends when coprocessor drops ack; done clears the count
        if (!ack) begin
          next_r.done  = 1'b1;
          next_r.count = BBR_CNT_RESET;
          if (!r.second_half) begin
            next_r.second_half = 1'b1;
            next_r.latch       = ~r.write;
            next_r.rword[BBR_LOW_LSB +: 16] = r.rword[BBR_LOW_LSB +: 16];
            next_r.state       = BBR_COUNT;
          end else begin
            next_r.ready = 1'b1;
            next_r.state = BBR_DONE;
          end
        end else if (!r.write) begin
          // sample read data while ack stands; last sample before release wins
          // the coprocessor keeps its data up until the strobe drops, after this
          if (r.second_half) begin
            next_r.rword[BBR_HIGH_LSB +: 16] = cop_rdata;
          end else begin
            next_r.rword[BBR_LOW_LSB +: 16] = cop_rdata;
          end
        end
      end
      BBR_DONE: begin
        // ready stands this cycle; the transfer_active ends with it
        next_r.active = 1'b0;
        next_r.state  = BBR_RECOV;
      end
      BBR_RECOV: begin
        // one idle cycle so the processor strobe of this access is not retaken
        next_r.state = BBR_IDLE;
      end
      default: begin
        next_r.state = BBR_IDLE;
      end
    endcase
    // write half chosen one cycle ahead, so the data pins come from a flip-flop
    next_r.wdata_out = half_of(next_r.wword, next_r.second_half);
  end

  // single register stage for all state; reset drops every control output at once,
  // which also abandons a half that was in flight on the coprocessor side
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '{state: BBR_IDLE, count: BBR_CNT_RESET, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // coprocessor command, active in command and ack phases
  // strobes drop between halves so the coprocessor sees two separate commands,
  // while device select follows transfer_active and stays up across both
  always_comb begin
    logic cmd_on;
    cmd_on = (r.state == BBR_CMD) || (r.state == BBR_ACK);
    cop_cmd.read_strobe         = cmd_on & ~r.write;
    cop_cmd.store_strobe        = cmd_on & r.write;
    cop_cmd.memory_or_io_select = cmd_on & r.mem_io;
    cop_cmd.device_select       = r.active;
    cop_cmd.byte_select_bit     = sel_bs;
    cop_cmd.halfword_select_bit = sel_hw;
    cop_cmd.high_byte_enable    = cmd_on & sel_hb;
    // lower half first, upper half second
    cop_cmd.wdata = r.wdata_out;
  end

  // transceiver enables, gated by ack; the b side drives also by byte enables
  // the first read half is captured by the latch pulse, so the processor side
  // is only driven once the whole word is assembled
  always_comb begin
    logic ack_on;
    ack_on = ack && (r.state == BBR_ACK);
    xcvr.direction          = r.write;
    xcvr.low_half_b_drive   = ack_on & r.write & ~r.second_half
                              & lanes_on(r.byte_en, 1'b0);
    xcvr.high_half_b_drive  = ack_on & r.write & r.second_half
                              & lanes_on(r.byte_en, 1'b1);
    xcvr.low_half_a_drive   = ack_on & ~r.write & r.second_half;
    xcvr.high_half_a_drive  = ack_on & ~r.write & r.second_half;
    xcvr.half_output_enable = r.latch;
  end

  // status outputs straight from the register record; pulses last one cycle,
  // the read word holds until the next read replaces it
  assign cpu_rdata       = r.rword;
  assign half_word_done  = r.done;
  assign cpu_ready       = r.ready;
  assign transfer_active = r.active;

endmodule

// File: hdl/bbr_pkg.sv
package bbr_pkg;

  // command generator timing: cycles counted from transfer start to strobe
  localparam logic [3:0] BBR_CMD_DELAY   = 4'h2;
  localparam logic [3:0] BBR_CNT_RESET   = 4'h0;
  localparam logic [3:0] BBR_CNT_MAX     = 4'hF;
  // field positions
  localparam int         BBR_LOW_LSB     = 0;
  localparam int         BBR_HIGH_LSB    = 16;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    BBR_IDLE   = 6'h01,  // waiting for a processor access
    BBR_COUNT  = 6'h02,  // counting before command
    BBR_CMD    = 6'h04,  // command out, waiting for slave_access_ack
    BBR_ACK    = 6'h08,  // ack seen, waiting for it to drop
    BBR_DONE   = 6'h10,  // processor ready pulse
    BBR_RECOV  = 6'h20   // strobes, device select and drives inactive before next access
  } bbr_state_t;

  // processor side request bundle
  typedef struct packed {
    logic        addr_strobe;   // address strobe, active high
    logic        data_enable;   // data enable, active high
    logic        device_select; // decoded graphics region select
    logic        write;         // 1 write, 0 read
    logic        mem_io;        // memory (1) or io (0) access
    logic [3:0]  byte_en;       // byte enables, active high
    logic [31:0] wdata;         // processor write word
  } bbr_cpu_req_t;

  // coprocessor side command bundle
  typedef struct packed {
    logic        read_strobe;         // read command
    logic        store_strobe;        // write command
    logic        memory_or_io_select; // memory or io select
    logic        device_select;       // chip select to coprocessor
    logic        byte_select_bit;     // low address bit
    logic        halfword_select_bit; // halfword address bit
    logic        high_byte_enable;    // high byte enable
    logic [15:0] wdata;               // 16-bit write data
  } bbr_cop_cmd_t;

  // transceiver controls
  typedef struct packed {
    logic direction;          // 1 processor to coprocessor
    logic low_half_b_drive;   // lower half, drive b (coprocessor) side
    logic low_half_a_drive;   // lower half, drive a (processor) side
    logic high_half_b_drive;  // upper half, drive b side
    logic high_half_a_drive;  // upper half, drive a side
    logic half_output_enable; // latch clock for the first read half
  } bbr_xcvr_t;

endpackage

// File: tb/bbr_bridge_chk.sv
`timescale 1ns/100ps
// watches strobe timing, the two halves, ready and transceiver drives
module bbr_bridge_chk
  import bbr_pkg::*;
(
  input wire logic         mclk,             // clock
  input wire logic         rst,              // reset
  input wire bbr_cpu_req_t cpu_req,          // request
  input wire logic         slave_access_ack, // ack pin
  input wire logic [15:0]  cop_rdata,        // read data
  input wire bbr_cop_cmd_t cop_cmd,          // command
  input wire bbr_xcvr_t    xcvr,             // transceivers
  input wire logic [31:0]  cpu_rdata,        // word
  input wire logic         half_word_done,   // half done
  input wire logic         cpu_ready,        // ready
  input wire logic         transfer_active   // in progress
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic strb;
  logic drv;
  logic [15:0] half;
  // ack pin passes a two-flop synchroniser, so drives lag it by up to three cycles
  assign strb = cop_cmd.read_strobe | cop_cmd.store_strobe;
  assign drv = xcvr.low_half_b_drive | xcvr.low_half_a_drive | xcvr.high_half_b_drive
             | xcvr.high_half_a_drive;
  assign half = cop_cmd.halfword_select_bit ? cpu_req.wdata[31:16] : cpu_req.wdata[15:0];
  sequence s_count;
    (!strb) [*3] ##1 strb;
  endsequence
  sequence s_recover;
    !transfer_active ##1 !transfer_active;
  endsequence
  a_cmd_delay: assert property ($rose(transfer_active) |-> s_count)
    else $error("command strobe delay wrong");
  a_done_pulse: assert property (half_word_done |=> !half_word_done)
    else $error("half done longer than one cycle");
  a_ready_second: assert property (cpu_ready
    |-> half_word_done && cop_cmd.halfword_select_bit) else $error("ready not from second half");
  a_first_bump: assert property (half_word_done && !cpu_ready
    |-> cop_cmd.halfword_select_bit) else $error("halfword bit not advanced");
  a_dir_write: assert property (transfer_active |-> xcvr.direction == cpu_req.write)
    else $error("direction wrong");
  a_drive_ack: assert property (drv |-> transfer_active && ($past(slave_access_ack)
    || $past(slave_access_ack, 2) || $past(slave_access_ack, 3))) else $error("drive without ack");
  a_word_both: assert property (xcvr.high_half_a_drive |-> xcvr.low_half_a_drive)
    else $error("upper word half driven alone");
  a_latch_read: assert property (xcvr.half_output_enable |-> half_word_done && !cpu_ready
    && !xcvr.direction) else $error("latch pulse misplaced");
  a_half_data: assert property (strb |-> cop_cmd.high_byte_enable ==
    (cop_cmd.halfword_select_bit ? cpu_req.byte_en[3] : cpu_req.byte_en[1])
    && (!cop_cmd.store_strobe || cop_cmd.wdata == half))
    else $error("half data or byte enable wrong");
  a_ready_end: assert property (cpu_ready |=> s_recover)
    else $error("cycle not ended by ready");
  a_sel_held: assert property (cop_cmd.device_select == transfer_active)
    else $error("select not held through the transfer");
  a_mem_io: assert property (strb |-> cop_cmd.memory_or_io_select == cpu_req.mem_io)
    else $error("memory or io select wrong");
  a_byte_bit: assert property (strb |-> cop_cmd.byte_select_bit ==
    (cop_cmd.halfword_select_bit ? (!cpu_req.byte_en[2] && cpu_req.byte_en[3])
    : (!cpu_req.byte_en[0] && cpu_req.byte_en[1]))) else $error("byte select bit wrong");
  a_low_lane: assert property (xcvr.low_half_b_drive |-> xcvr.direction
    && !cop_cmd.halfword_select_bit && (|cpu_req.byte_en[1:0]))
    else $error("low lane drive wrong");
  a_high_lane: assert property (xcvr.high_half_b_drive |-> xcvr.direction
    && cop_cmd.halfword_select_bit && (|cpu_req.byte_en[3:2]))
    else $error("high lane drive wrong");
endmodule

bind bbr_bridge bbr_bridge_chk bbr_bridge_chk_i (.mclk, .rst, .cpu_req, .slave_access_ack,
  .cop_rdata, .cop_cmd, .xcvr, .cpu_rdata, .half_word_done, .cpu_ready, .transfer_active);

// File: tb/bbr_bridge_test.sv
`timescale 1ns/100ps
module bbr_bridge_test;
  import bbr_pkg::*;
  logic         mclk = 1'b0;
  logic         rst = 1'b1;
  bbr_cpu_req_t cpu_req = '0;
  logic [3:0]   dly = 4'h0;
  logic         mio = 1'b1;
  logic         ack, half_word_done, cpu_ready, transfer_active;
  logic [15:0]  cop_rdata;
  logic [31:0]  cpu_rdata, mem;
  bbr_cop_cmd_t cop_cmd;
  bbr_xcvr_t    xcvr;
  int           n_errors = 0;
  int           num_checks = 0;
  int           cycles = 0;
  bbr_bridge bbr_bridge_i (.mclk(mclk), .rst(rst), .cpu_req(cpu_req), .slave_access_ack(ack),
    .cop_rdata(cop_rdata), .cop_cmd(cop_cmd), .xcvr(xcvr), .cpu_rdata(cpu_rdata),
    .half_word_done(half_word_done), .cpu_ready(cpu_ready), .transfer_active(transfer_active));
  bbr_cop_model bbr_cop_model_i (.mclk(mclk), .rst(rst), .cmd(cop_cmd), .dly(dly), .ack(ack),
    .rdata(cop_rdata), .mem(mem));
  always #50 mclk = ~mclk;
  // a hang costs a mismatch; the whole run needs well under 2000 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  task end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until ready, then dropped; counts dones and latch pulses, collects which drives were seen
  task xfer(input logic wr, input logic [3:0] be, input logic [31:0] wd);
    int         dn;
    int         nl;
    logic [3:0] dv;
    logic [3:0] ev;
    dn = 0;
    nl = 0;
    dv = 4'h0;
    ev = wr ? {(|be[1:0]), 1'b0, (|be[3:2]), 1'b0} : 4'h5;
    @(negedge mclk);
    cpu_req = '{1'b1, 1'b1, 1'b1, wr, mio, be, wd};
    for (int i = 0; i < 300 && cpu_ready !== 1'b1; i++) begin
      @(negedge mclk);
      if (half_word_done === 1'b1) dn++;
      if (xcvr.half_output_enable === 1'b1) nl++;
      dv = dv | {xcvr.low_half_b_drive, xcvr.low_half_a_drive, xcvr.high_half_b_drive,
                 xcvr.high_half_a_drive};
    end
    check("half dones", 32'h2, dn);
    check("latch pulses", {31'h0, ~wr}, nl);
    check("transceiver drives", {28'h0, ev}, {28'h0, dv});
    cpu_req.addr_strobe = 1'b0;
    cpu_req.data_enable = 1'b0;
    cpu_req.device_select = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task t_word(input logic [3:0] d, input logic [31:0] w);
    dly = d;
    xfer(1'b1, 4'hF, w);
    check("stored word", w, mem);
    xfer(1'b0, 4'hF, 32'h0);
    check("read word", w, cpu_rdata);
    $display("word test done, ack delay %0d", d);
  endtask
  task t_lanes;
    logic [3:0] be [4] = '{4'h3, 4'hC, 4'h1, 4'h8};
    dly = 4'h2;
    foreach (be[k]) begin
      mio = k[1]; // io cycles first, then memory cycles
      xfer(k[0], be[k], 32'h5A5A_C3C3);
    end
    mio = 1'b1;
    $display("lane test done");
  endtask
  task t_reset_mid;
    @(negedge mclk);
    cpu_req = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 32'h0};
    repeat (6) @(negedge mclk);
    rst = 1'b1;
    cpu_req = '0;
    @(negedge mclk);
    check("active in reset", 32'h0, {31'h0, transfer_active});
    check("strobe in reset", 32'h0, {31'h0, cop_cmd.store_strobe});
    rst = 1'b0;
    t_word(4'h1, 32'h0F1E_2D3C);
    $display("reset test done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    t_word(4'h0, 32'h1234_5678);
    t_word(4'h9, 32'hA5C3_0F96);
    t_lanes();
    t_reset_mid();
    end_sim();
  end
endmodule

// File: tb/bbr_cop_model.sv
`timescale 1ns/100ps
// coprocessor in slave mode: one word of memory, ack after a set delay
module bbr_cop_model
  import bbr_pkg::*;
(
  input wire logic         mclk,  // clock
  input wire logic         rst,   // reset
  input wire bbr_cop_cmd_t cmd,   // command from the bridge
  input wire logic [3:0]   dly,   // cycles before ack
  output logic             ack,   // slave access ack
  output logic [15:0]      rdata, // read data
  output logic [31:0]      mem    // stored word
);
  logic [3:0] cnt;
  logic       served;
  logic       on;
  assign on = cmd.read_strobe | cmd.store_strobe;
  // data is released once the strobe drops; inverse stops stale data passing
  assign rdata = (on && served) ? (cmd.halfword_select_bit ? mem[31:16] : mem[15:0])
                                : ~mem[15:0];
  // one ack per strobe: wait, hold four cycles, drop, then wait for strobe off
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      cnt <= 4'h0;
      served <= 1'b0;
      mem <= 32'h0;
    end else if (!on) begin
      ack <= 1'b0;
      cnt <= 4'h0;
      served <= 1'b0;
    end else if (!served) begin
      cnt <= cnt + 4'h1;
      if (cnt == dly) begin
        ack <= 1'b1;
        served <= 1'b1;
        cnt <= 4'h0;
        if (cmd.store_strobe && cmd.halfword_select_bit) mem[31:16] <= cmd.wdata;
        if (cmd.store_strobe && !cmd.halfword_select_bit) mem[15:0] <= cmd.wdata;
      end
    end else if (ack) begin
      cnt <= cnt + 4'h1;
      if (cnt == 4'h3) ack <= 1'b0;
    end
  end
endmodule
